// [design/pio_pkg.sv]
// Shared constants for the programmed I/O device interface
package pio_pkg;
   // Word and field widths
   localparam int WORD_W = 16;
   localparam int ADDR_W = 11;
   localparam int IDENT_W = 9;
   localparam int LEVEL_W = 6;
   localparam int ERR_W = 4;
   localparam int UNIT_W = 2;
   localparam int MODE_W = 5;
   localparam int EXT_W = 2;
   // Register offsets within a device number (low three address bits)
   localparam logic [2:0] OFF_RX_DATA = 3'h0;
   localparam logic [2:0] OFF_RX_STAT = 3'h2;
   localparam logic [2:0] OFF_RX_CTRL = 3'h3;
   localparam logic [2:0] OFF_TX_DATA = 3'h5;
   localparam logic [2:0] OFF_TX_STAT = 3'h6;
   localparam logic [2:0] OFF_TX_CTRL = 3'h7;
   // Offsets of the direct memory access channel at its own device number
   localparam logic [2:0] OFF_DMA_MEM_RD = 3'h0;
   localparam logic [2:0] OFF_DMA_MEM_WR = 3'h1;
   localparam logic [2:0] OFF_DMA_STAT = 3'h2;
   localparam logic [2:0] OFF_DMA_CNT_WR = 3'h3;
   localparam logic [2:0] OFF_DMA_CNT_RD = 3'h4;
   localparam logic [2:0] OFF_DMA_DEV_WR = 3'h5;
   localparam logic [2:0] OFF_DMA_DEV_RD = 3'h6;
   localparam logic [2:0] OFF_DMA_CTRL = 3'h7;
   // Address bit that marks an output transfer
   localparam int ADDR_OUT_BIT = 0;
   localparam int ADDR_SEL_W = 3;
   // Control word fields
   localparam int CW_RDY_IE = 0;
   localparam int CW_ERR_IE = 1;
   localparam int CW_ACT = 2;
   localparam int CW_TEST = 3;
   localparam int CW_CLR = 4;
   localparam int CW_EXT_LO = 5;
   localparam int CW_UNIT_LO = 9;
   localparam int CW_MODE_LO = 11;
   localparam int CW_DIR = 11;
   // Status word fields
   localparam int SW_RDY_IE = 0;
   localparam int SW_ERR_IE = 1;
   localparam int SW_ACTIVE = 2;
   localparam int SW_READY = 3;
   localparam int SW_ERR_OR = 4;
   localparam int SW_ERR_LO = 5;
   localparam int SW_UNIT_LO = 9;
   localparam int SW_MODE_LO = 11;
   // Reset values and the one-word step
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;
   localparam logic [IDENT_W-1:0] IDENT_ZERO = 9'h000;
endpackage

// [design/pio_sync.sv]
// Two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module pio_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rstSync_n,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r; // First stage, read only by the second

   // Both stages clear on reset; the second feeds the logic
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         stage1_r <= '0;
         syncOut <= '0;
      end else begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end
endmodule

// [design/pio_dma_channel.sv]
// Direct memory access channel set up through programmed register writes
`timescale 1ns/1ps
module pio_dma_channel (
   input wire logic mclk,
   input wire logic rstSync_n,
   input wire logic wrMem,
   input wire logic wrCnt,
   input wire logic wrDev,
   input wire logic wrCtrl,
   input wire logic [pio_pkg::WORD_W-1:0] wdata,
   input wire logic grant,
   input wire logic errLevel,
   output logic [pio_pkg::WORD_W-1:0] memAddr_r,
   output logic [pio_pkg::WORD_W-1:0] wordCnt_r,
   output logic [pio_pkg::WORD_W-1:0] devAddr_r,
   output logic [pio_pkg::WORD_W-1:0] ctrl_r,
   output logic active_r,
   output logic ready_r,
   output logic errFlag_r,
   output logic doneEv_r,
   output logic errEv_r
);
   logic errPrev_r; // Last error level, for edge detection
   logic startCmd; // Control write that carries the activate code
   logic errRise; // New error while the transfer runs
   logic lastWord; // Grant taken for the final word

   assign startCmd = wrCtrl && wdata[pio_pkg::CW_ACT] && (wordCnt_r != pio_pkg::WORD_ZERO);
   assign errRise = errLevel && !errPrev_r && active_r;
   assign lastWord = active_r && grant && (wordCnt_r == pio_pkg::WORD_ONE);

   // Setup registers; address and count step once per granted word
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         memAddr_r <= pio_pkg::WORD_ZERO;
         wordCnt_r <= pio_pkg::WORD_ZERO;
         devAddr_r <= pio_pkg::WORD_ZERO;
         ctrl_r <= pio_pkg::WORD_ZERO;
      end else begin
         if (wrMem) memAddr_r <= wdata;
         else if (active_r && grant) memAddr_r <= memAddr_r + pio_pkg::WORD_ONE;
         if (wrCnt) wordCnt_r <= wdata;
         else if (active_r && grant) wordCnt_r <= wordCnt_r - pio_pkg::WORD_ONE;
         if (wrDev) devAddr_r <= wdata;
         if (wrCtrl) ctrl_r <= wdata;
      end
   end

   // Run state, completion and error reporting
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         active_r <= 1'b0;
         ready_r <= 1'b0;
         errFlag_r <= 1'b0;
         errPrev_r <= 1'b0;
         doneEv_r <= 1'b0;
         errEv_r <= 1'b0;
      end else begin
         errPrev_r <= errLevel;
         doneEv_r <= lastWord;
         errEv_r <= errRise;
         if (wrCtrl && wdata[pio_pkg::CW_CLR]) begin
            // Device clear stops the channel; an event in the same cycle still sets its flag
            active_r <= 1'b0;
            ready_r <= lastWord;
            errFlag_r <= errRise;
         end else if (startCmd) begin
            // Only the activate code starts a transfer
            active_r <= 1'b1;
            ready_r <= 1'b0;
            errFlag_r <= errRise;
         end else if (errRise) begin
            active_r <= 1'b0;
            errFlag_r <= 1'b1;
         end else if (lastWord) begin
            active_r <= 1'b0;
            ready_r <= 1'b1;
         end
      end
   end
endmodule

// [design/pio_device_interface.sv]
// Programmed I/O device interface with input, output and DMA register sets
`timescale 1ns/1ps
// Function
// - Status bits 0,1 show interrupt enables
// - Status bit 2 active, bit 3 ready
// - Bit 4 ORs errors, bits 5-8 errors
// - Status bits 9,10 show selected unit
// - Status bits 11-15 show operational mode
// - Control bit 0 enables ready interrupt
// - Control bit 1 enables error interrupt
// - Control bit 2 activates, starts transfer
// - Control bits 11-15 select device operation
// - Control write-only, status read-only
// - Data two-way; separate sets per direction
// - Input: status flags data, host polls
// - Output: data handed over, status then changes
// - Interrupt each time device becomes ready
// - Input 0,2,3; output 5,6,7 offsets
// - DMA set up by programmed writes first
// - DMA starts only on activate code
// - DMA interrupts on completion or error
// - DMA address advances once per word
// - Address bit 0 output; low bits select
// - Own device number answers with connect
// - Identify returns 9-bit code, clears pending
module pio_device_interface #(
   parameter logic [7:0] DEV_NUM = 8'h18, // Device number of the terminal pair
   parameter logic [7:0] DMA_NUM = 8'h19, // Device number of the DMA channel
   parameter logic [pio_pkg::LEVEL_W-1:0] IRQ_LEVEL = 6'h0C, // Interrupt level served
   parameter logic [pio_pkg::IDENT_W-1:0] RX_IDENT = 9'h001, // Arbitrary value
   parameter logic [pio_pkg::IDENT_W-1:0] TX_IDENT = 9'h002, // Arbitrary value
   parameter logic [pio_pkg::IDENT_W-1:0] DMA_IDENT = 9'h003 // Arbitrary value
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [pio_pkg::ADDR_W-1:0] ioAddr,
   input wire logic ioxStrobe,
   input wire logic identStrobe,
   input wire logic [pio_pkg::WORD_W-1:0] ioDataIn,
   output logic [pio_pkg::WORD_W-1:0] ioDataOut,
   output logic connect,
   output logic inputTransfer,
   output logic [pio_pkg::IDENT_W-1:0] identCode,
   output logic identValid,
   output logic irq,
   input wire logic perRxStrobe,
   input wire logic [pio_pkg::WORD_W-1:0] perRxData,
   input wire logic [pio_pkg::ERR_W-1:0] perRxErr,
   output logic perRxRequest,
   output logic [pio_pkg::MODE_W-1:0] perRxMode,
   input wire logic perTxAck,
   input wire logic [pio_pkg::ERR_W-1:0] perTxErr,
   output logic perTxValid,
   output logic [pio_pkg::WORD_W-1:0] perTxData,
   output logic [pio_pkg::MODE_W-1:0] perTxMode,
   output logic dmaReq,
   output logic [pio_pkg::EXT_W+pio_pkg::WORD_W-1:0] dmaAddr,
   output logic dmaWrite,
   output logic [pio_pkg::WORD_W-1:0] dmaDevAddr,
   input wire logic dmaGrant,
   input wire logic dmaErr
);
   localparam int SYNC_W = 2 + 2 * pio_pkg::ERR_W + pio_pkg::WORD_W + 1;

   // Builds a status word from a control word and channel state
   function automatic logic [pio_pkg::WORD_W-1:0] statusWord(
      input logic [pio_pkg::WORD_W-1:0] ctrl,
      input logic active,
      input logic ready,
      input logic [pio_pkg::ERR_W-1:0] err
   );
      logic [pio_pkg::WORD_W-1:0] s;
      s = pio_pkg::WORD_ZERO;
      s[pio_pkg::SW_RDY_IE] = ctrl[pio_pkg::CW_RDY_IE];
      s[pio_pkg::SW_ERR_IE] = ctrl[pio_pkg::CW_ERR_IE];
      s[pio_pkg::SW_ACTIVE] = active;
      s[pio_pkg::SW_READY] = ready;
      s[pio_pkg::SW_ERR_OR] = |err;
      s[pio_pkg::SW_ERR_LO +: pio_pkg::ERR_W] = err;
      s[pio_pkg::SW_UNIT_LO +: pio_pkg::UNIT_W] = ctrl[pio_pkg::CW_UNIT_LO +: pio_pkg::UNIT_W];
      s[pio_pkg::SW_MODE_LO +: pio_pkg::MODE_W] = ctrl[pio_pkg::CW_MODE_LO +: pio_pkg::MODE_W];
      return s;
   endfunction

   logic rstMeta_r; // Reset release, first stage
   logic rstSync_n; // Reset release, second stage
   logic [SYNC_W-1:0] syncVec; // Synchronised peripheral pins
   logic rxStrobeS; // Peripheral deposited data, level
   logic [pio_pkg::WORD_W-1:0] rxDataS; // Peripheral input data
   logic [pio_pkg::ERR_W-1:0] rxErrS; // Input error lines
   logic txAckS; // Peripheral took the output data
   logic [pio_pkg::ERR_W-1:0] txErrS; // Output error lines
   logic dmaErrS; // DMA error line
   logic rxStrobePrev_r; // Edge detection state
   logic txAckPrev_r;
   logic [pio_pkg::ERR_W-1:0] rxErrPrev_r;
   logic [pio_pkg::ERR_W-1:0] txErrPrev_r;
   logic [pio_pkg::WORD_W-1:0] rxCtrl_r; // Input control word
   logic [pio_pkg::WORD_W-1:0] txCtrl_r; // Output control word
   logic [pio_pkg::WORD_W-1:0] rxData_r; // Input data register
   logic [pio_pkg::WORD_W-1:0] txData_r; // Output data register
   logic rxActive_r, rxReady_r, txActive_r, txReady_r;
   logic [pio_pkg::ERR_W-1:0] rxErr_r; // Sticky input errors
   logic [pio_pkg::ERR_W-1:0] txErr_r; // Sticky output errors
   logic rxIrq_r, txIrq_r, dmaIrq_r; // Pending interrupt conditions
   logic devHit, dmaHit, wrCycle, rdCycle; // Bus decode
   logic [2:0] sel; // Register select
   logic rxCtrlWr, txCtrlWr, txDataWr, rxDataRd;
   logic rxReadyEv, txReadyEv; // Channel became ready
   logic [pio_pkg::ERR_W-1:0] rxErrRise, txErrRise;
   logic identHit, identRx, identTx, identDma;
   logic [pio_pkg::WORD_W-1:0] rdMux; // Selected read data
   logic [pio_pkg::WORD_W-1:0] dmaMem, dmaCnt, dmaDev, dmaCtrl;
   logic dmaActive, dmaReady, dmaErrFlag, dmaDoneEv, dmaErrEv;

   // Reset is applied at once and released through two flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_r <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstSync_n <= rstMeta_r;
      end
   end

   // Peripheral pins cross into the bus clock here
   pio_sync #(.WIDTH(SYNC_W)) pinSync (
      .mclk(mclk),
      .rstSync_n(rstSync_n),
      .asyncIn({perRxStrobe, perRxData, perRxErr, perTxAck, perTxErr, dmaErr}),
      .syncOut(syncVec)
   );
   assign {rxStrobeS, rxDataS, rxErrS, txAckS, txErrS, dmaErrS} = syncVec;

   // Bus decode: device number in the upper bits, output on bit 0
   assign devHit = ioxStrobe && (ioAddr[pio_pkg::ADDR_W-1:pio_pkg::ADDR_SEL_W] == DEV_NUM);
   assign dmaHit = ioxStrobe && (ioAddr[pio_pkg::ADDR_W-1:pio_pkg::ADDR_SEL_W] == DMA_NUM);
   assign wrCycle = ioAddr[pio_pkg::ADDR_OUT_BIT];
   assign rdCycle = !ioAddr[pio_pkg::ADDR_OUT_BIT];
   assign sel = ioAddr[pio_pkg::ADDR_SEL_W-1:0];
   // Control offsets are odd, so they only take writes; status offsets are even
   assign rxCtrlWr = devHit && wrCycle && (sel == pio_pkg::OFF_RX_CTRL);
   assign txCtrlWr = devHit && wrCycle && (sel == pio_pkg::OFF_TX_CTRL);
   assign txDataWr = devHit && wrCycle && (sel == pio_pkg::OFF_TX_DATA);
   assign rxDataRd = devHit && rdCycle && (sel == pio_pkg::OFF_RX_DATA);

   // Channel events taken from the synchronised pins
   assign rxReadyEv = rxStrobeS && !rxStrobePrev_r && rxActive_r;
   assign txReadyEv = txAckS && !txAckPrev_r && txActive_r;
   assign rxErrRise = rxErrS & ~rxErrPrev_r;
   assign txErrRise = txErrS & ~txErrPrev_r;

   // Edge detection history
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rxStrobePrev_r <= 1'b0;
         txAckPrev_r <= 1'b0;
         rxErrPrev_r <= '0;
         txErrPrev_r <= '0;
      end else begin
         rxStrobePrev_r <= rxStrobeS;
         txAckPrev_r <= txAckS;
         rxErrPrev_r <= rxErrS;
         txErrPrev_r <= txErrS;
      end
   end

   // Control words are stored as written
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rxCtrl_r <= pio_pkg::WORD_ZERO;
         txCtrl_r <= pio_pkg::WORD_ZERO;
      end else begin
         if (rxCtrlWr) rxCtrl_r <= ioDataIn;
         if (txCtrlWr) txCtrl_r <= ioDataIn;
      end
   end

   // Data registers: input filled by the peripheral, output by the host
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rxData_r <= pio_pkg::WORD_ZERO;
         txData_r <= pio_pkg::WORD_ZERO;
      end else begin
         if (rxReadyEv) rxData_r <= rxDataS;
         if (txDataWr) txData_r <= ioDataIn;
      end
   end

   // Input channel run state; a new deposit wins over a same-cycle read
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rxActive_r <= 1'b0;
         rxReady_r <= 1'b0;
         rxErr_r <= '0;
      end else begin
         if (rxCtrlWr && ioDataIn[pio_pkg::CW_CLR]) begin
            // Device clear; a deposit in the same cycle still sets ready
            rxActive_r <= 1'b0;
            rxReady_r <= rxReadyEv;
            rxErr_r <= rxErrRise;
         end else if (rxCtrlWr && ioDataIn[pio_pkg::CW_ACT]) begin
            rxActive_r <= 1'b1;
            rxReady_r <= 1'b0;
            rxErr_r <= rxErrRise;
         end else begin
            if (rxDataRd) rxReady_r <= 1'b0;
            if (rxReadyEv) begin
               rxActive_r <= 1'b0;
               rxReady_r <= 1'b1;
            end
            rxErr_r <= rxErr_r | rxErrRise;
         end
      end
   end

   // Output channel run state; data is offered while active
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         txActive_r <= 1'b0;
         txReady_r <= 1'b0;
         txErr_r <= '0;
      end else begin
         if (txCtrlWr && ioDataIn[pio_pkg::CW_CLR]) begin
            // Device clear; a hand-over in the same cycle still sets ready
            txActive_r <= 1'b0;
            txReady_r <= txReadyEv;
            txErr_r <= txErrRise;
         end else if (txCtrlWr && ioDataIn[pio_pkg::CW_ACT]) begin
            txActive_r <= 1'b1;
            txReady_r <= 1'b0;
            txErr_r <= txErrRise;
         end else begin
            if (txReadyEv) begin
               txActive_r <= 1'b0;
               txReady_r <= 1'b1;
            end
            txErr_r <= txErr_r | txErrRise;
         end
      end
   end

   // DMA channel at its own device number
   pio_dma_channel dma (
      .mclk(mclk),
      .rstSync_n(rstSync_n),
      .wrMem(dmaHit && wrCycle && (sel == pio_pkg::OFF_DMA_MEM_WR)),
      .wrCnt(dmaHit && wrCycle && (sel == pio_pkg::OFF_DMA_CNT_WR)),
      .wrDev(dmaHit && wrCycle && (sel == pio_pkg::OFF_DMA_DEV_WR)),
      .wrCtrl(dmaHit && wrCycle && (sel == pio_pkg::OFF_DMA_CTRL)),
      .wdata(ioDataIn),
      .grant(dmaGrant),
      .errLevel(dmaErrS),
      .memAddr_r(dmaMem),
      .wordCnt_r(dmaCnt),
      .devAddr_r(dmaDev),
      .ctrl_r(dmaCtrl),
      .active_r(dmaActive),
      .ready_r(dmaReady),
      .errFlag_r(dmaErrFlag),
      .doneEv_r(dmaDoneEv),
      .errEv_r(dmaErrEv)
   );
   assign dmaReq = dmaActive;
   assign dmaAddr = {dmaCtrl[pio_pkg::CW_EXT_LO +: pio_pkg::EXT_W], dmaMem};
   assign dmaWrite = dmaCtrl[pio_pkg::CW_DIR];
   assign dmaDevAddr = dmaDev;

   // Identify cycle: first pending source on our level answers
   assign identHit = identStrobe && (ioAddr[pio_pkg::LEVEL_W-1:0] == IRQ_LEVEL);
   assign identRx = identHit && rxIrq_r;
   assign identTx = identHit && txIrq_r && !rxIrq_r;
   assign identDma = identHit && dmaIrq_r && !rxIrq_r && !txIrq_r;

   // Pending conditions; a new event wins over a same-cycle acknowledge
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rxIrq_r <= 1'b0;
         txIrq_r <= 1'b0;
         dmaIrq_r <= 1'b0;
      end else begin
         if (identRx || (rxCtrlWr && ioDataIn[pio_pkg::CW_CLR])) rxIrq_r <= 1'b0;
         if ((rxReadyEv && rxCtrl_r[pio_pkg::CW_RDY_IE]) || ((|rxErrRise) && rxCtrl_r[pio_pkg::CW_ERR_IE]))
            rxIrq_r <= 1'b1;
         if (identTx || (txCtrlWr && ioDataIn[pio_pkg::CW_CLR])) txIrq_r <= 1'b0;
         if ((txReadyEv && txCtrl_r[pio_pkg::CW_RDY_IE]) || ((|txErrRise) && txCtrl_r[pio_pkg::CW_ERR_IE]))
            txIrq_r <= 1'b1;
         if (identDma) dmaIrq_r <= 1'b0;
         if ((dmaDoneEv && dmaCtrl[pio_pkg::CW_RDY_IE]) || (dmaErrEv && dmaCtrl[pio_pkg::CW_ERR_IE]))
            dmaIrq_r <= 1'b1;
      end
   end
   assign irq = rxIrq_r || txIrq_r || dmaIrq_r;

   // Read multiplexer over the input, output and DMA register sets; unused offsets read zero
   always_comb begin
      rdMux = pio_pkg::WORD_ZERO;
      if (devHit) begin
         unique case (sel)
            pio_pkg::OFF_RX_DATA: rdMux = rxData_r;
            pio_pkg::OFF_RX_STAT: rdMux = statusWord(rxCtrl_r, rxActive_r, rxReady_r, rxErr_r);
            pio_pkg::OFF_TX_STAT: rdMux = statusWord(txCtrl_r, txActive_r, txReady_r, txErr_r);
            default: rdMux = pio_pkg::WORD_ZERO;
         endcase
      end else if (dmaHit) begin
         unique case (sel)
            pio_pkg::OFF_DMA_MEM_RD: rdMux = dmaMem;
            pio_pkg::OFF_DMA_STAT: rdMux = statusWord(dmaCtrl, dmaActive, dmaReady, {3'b000, dmaErrFlag});
            pio_pkg::OFF_DMA_CNT_RD: rdMux = dmaCnt;
            pio_pkg::OFF_DMA_DEV_RD: rdMux = dmaDev;
            default: rdMux = pio_pkg::WORD_ZERO;
         endcase
      end
   end

   // Bus answer, one cycle after the strobe
   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         connect <= 1'b0;
         inputTransfer <= 1'b0;
         ioDataOut <= pio_pkg::WORD_ZERO;
         identValid <= 1'b0;
         identCode <= pio_pkg::IDENT_ZERO;
      end else begin
         connect <= devHit || dmaHit;
         inputTransfer <= (devHit || dmaHit) && rdCycle;
         ioDataOut <= (rdCycle && (devHit || dmaHit)) ? rdMux : pio_pkg::WORD_ZERO;
         identValid <= identRx || identTx || identDma;
         if (identRx) identCode <= RX_IDENT;
         else if (identTx) identCode <= TX_IDENT;
         else if (identDma) identCode <= DMA_IDENT;
         else identCode <= pio_pkg::IDENT_ZERO;
      end
   end

   // Peripheral side
   assign perRxRequest = rxActive_r;
   assign perRxMode = rxCtrl_r[pio_pkg::CW_MODE_LO +: pio_pkg::MODE_W];
   assign perTxValid = txActive_r;
   assign perTxData = txData_r;
   assign perTxMode = txCtrl_r[pio_pkg::CW_MODE_LO +: pio_pkg::MODE_W];
endmodule

// [verif/pio_checker.sv]
// Port checker for the programmed I/O device interface
`timescale 1ns/1ps
module pio_checker (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [10:0] ioAddr,
   input wire logic ioxStrobe,
   input wire logic identStrobe,
   input wire logic [15:0] ioDataOut,
   input wire logic connect,
   input wire logic inputTransfer,
   input wire logic [8:0] identCode,
   input wire logic identValid
);
   // All checks on the system clock, quiet while the pin reset is low
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   a_connect_cause: assert property (connect |-> $past(ioxStrobe) && $past(ioAddr[10:4]) == 7'h0C) else $error("stray");
   a_foreign_quiet: assert property (ioxStrobe && ioAddr[10:4] != 7'h0C |=> !connect) else $error("foreign answer");
   a_read_flag: assert property (ioxStrobe && ioAddr[10:4] == 7'h0C |=> inputTransfer != $past(ioAddr[0])) else $error("dir");
   a_read_pair: assert property (inputTransfer |-> connect) else $error("read flag alone");
   a_data_idle: assert property (!inputTransfer |-> ioDataOut == 16'h0000) else $error("data out of turn");
   a_ident_cause: assert property (identValid |-> $past(identStrobe) && $past(ioAddr[5:0]) == 6'h0C) else $error("id");
   a_ident_level: assert property (identStrobe && ioAddr[5:0] != 6'h0C |=> !identValid) else $error("wrong level");
   a_ident_idle: assert property (!identValid |-> identCode == 9'h000) else $error("code out of turn");
endmodule

bind pio_device_interface pio_checker pio_checker_i (.mclk(mclk), .reset_n(reset_n), .ioAddr(ioAddr),
   .ioxStrobe(ioxStrobe), .identStrobe(identStrobe), .ioDataOut(ioDataOut), .connect(connect),
   .inputTransfer(inputTransfer), .identCode(identCode), .identValid(identValid));

// [verif/pio_peripheral_model.sv]
// Behavioural peripheral on the far side of the data channels
`timescale 1ns/1ps
module pio_peripheral_model (
   input wire logic mclk,
   input wire logic perRxRequest,
   input wire logic perTxValid,
   input wire logic [15:0] rxWord,
   input wire logic [3:0] gap,
   output logic perRxStrobe = 1'b0,
   output logic [15:0] perRxData = 16'h0000,
   output logic perTxAck = 1'b0
);
   // Input side: one deposit per activation, data set a cycle before the strobe and held until the strobe drops
   always begin
      @(posedge mclk iff perRxRequest === 1'b1);
      repeat (gap) @(posedge mclk);
      perRxData <= rxWord;
      @(posedge mclk);
      perRxStrobe <= 1'b1;
      repeat (6) @(posedge mclk);
      perRxStrobe <= 1'b0;
      perRxData <= ~rxWord; // Released lines no longer show the word
      @(posedge mclk iff perRxRequest !== 1'b1);
   end
   // Output side: take the offered word after a delay, drop ack when the offer ends
   always begin
      @(posedge mclk iff perTxValid === 1'b1);
      repeat (gap) @(posedge mclk);
      perTxAck <= 1'b1;
      @(posedge mclk iff perTxValid !== 1'b1);
      perTxAck <= 1'b0;
   end
endmodule

// [verif/pio_device_interface_bench.sv]
// Self-checking bench for the programmed I/O device interface
`timescale 1ns/1ps
module pio_device_interface_bench;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic ioxStrobe = 1'b0;
   logic identStrobe = 1'b0;
   logic [10:0] ioAddr = 11'h000;
   logic [15:0] ioDataIn = 16'h0000;
   logic [3:0] perRxErr = 4'h0;
   logic [3:0] gap = 4'h4; // Partner reply delay
   logic [15:0] ioDataOut, perRxData, perTxData, q, dmaDevAddr;
   logic [17:0] dmaAddr; // DMA memory address with extension bits
   logic [8:0] identCode;
   logic [4:0] perRxMode, perTxMode;
   logic connect, identValid, irq, perRxStrobe, perRxRequest, perTxAck, perTxValid, dmaReq, dmaWrite;
   int nFail = 0;
   int nTests = 0;
   // Memory side grants every cycle it is asked
   pio_device_interface pio_device_interface_i (.mclk(mclk), .reset_n(reset_n), .ioAddr(ioAddr),
      .ioxStrobe(ioxStrobe), .identStrobe(identStrobe), .ioDataIn(ioDataIn), .ioDataOut(ioDataOut),
      .connect(connect), .inputTransfer(), .identCode(identCode), .identValid(identValid), .irq(irq),
      .perRxStrobe(perRxStrobe), .perRxData(perRxData), .perRxErr(perRxErr), .perRxRequest(perRxRequest),
      .perRxMode(perRxMode), .perTxAck(perTxAck), .perTxErr(4'h0), .perTxValid(perTxValid), .perTxData(perTxData),
      .perTxMode(perTxMode), .dmaReq(dmaReq), .dmaAddr(dmaAddr), .dmaWrite(dmaWrite), .dmaDevAddr(dmaDevAddr),
      .dmaGrant(dmaReq), .dmaErr(1'b0));
   pio_peripheral_model pio_peripheral_model_i (.mclk(mclk), .perRxRequest(perRxRequest), .perTxValid(perTxValid),
      .rxWord(16'h1234), .gap(gap), .perRxStrobe(perRxStrobe), .perRxData(perRxData), .perTxAck(perTxAck));
   initial forever #2.5 mclk = ~mclk;
   // Cycle ceiling against a hang
   initial begin
      repeat (3000) @(posedge mclk);
      nFail++;
      finalReport();
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      nTests++;
      if (seen !== want) nFail++;
      if (seen !== want) $display("wrong value at %0t: %h not %h", $time, seen, want);
   endtask
   task automatic finalReport();
      $display("checks %0d mismatches %0d", nTests, nFail);
      if (nFail == 0 && nTests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One bus transfer; read data lands in q
   task automatic io(input logic [10:0] a, input logic [15:0] d, input logic c);
      @(posedge mclk);
      ioAddr <= a;
      ioDataIn <= d;
      ioxStrobe <= 1'b1;
      @(posedge mclk);
      ioxStrobe <= 1'b0;
      #1 q = ioDataOut;
      chk(16'(connect), 16'(c));
   endtask
   task automatic ident(input logic [8:0] e);
      @(posedge mclk);
      ioAddr <= 11'h00C;
      identStrobe <= 1'b1;
      @(posedge mclk);
      identStrobe <= 1'b0;
      #1 chk(16'(identCode), 16'(e));
      chk(16'(identValid), 16'(e != 9'h000));
   endtask
   // Poll a status word until ready, bounded
   task automatic waitRdy(input logic [10:0] a);
      q = 16'h0000;
      for (int i = 0; i < 40 && q[3] !== 1'b1; i++) io(a, 16'h0000, 1'b1);
   endtask
   task automatic tStatus();
      io(11'h0D2, 16'h0000, 1'b0);
      io(11'h0C3, 16'hFE02, 1'b1);
      chk(16'(perRxMode), 16'h001F);
      @(posedge mclk);
      perRxErr <= 4'h4;
      repeat (6) @(posedge mclk);
      io(11'h0C2, 16'h0000, 1'b1);
      chk(q, 16'hFE92);
      chk(16'(irq), 16'h0001);
      @(posedge mclk);
      perRxErr <= 4'h0;
      ident(9'h001);
      io(11'h0C3, 16'h0010, 1'b1);
      io(11'h0C2, 16'h0000, 1'b1);
      chk(q, 16'h0000);
   endtask
   task automatic tInput();
      io(11'h0C3, 16'h0005, 1'b1);
      chk(16'(perRxRequest), 16'h0001);
      io(11'h0C2, 16'h0000, 1'b1);
      chk(q, 16'h0005);
      waitRdy(11'h0C2);
      chk(q, 16'h0009);
      chk(16'(irq), 16'h0001);
      ident(9'h001);
      chk(16'(irq), 16'h0000);
      io(11'h0C0, 16'h0000, 1'b1);
      chk(q, 16'h1234);
   endtask
   task automatic tOutput();
      gap = 4'h8;
      io(11'h0C5, 16'hA5C3, 1'b1);
      io(11'h0C7, 16'h3004, 1'b1);
      chk(perTxData, 16'hA5C3);
      chk(16'(perTxValid), 16'h0001);
      chk(16'(perTxMode), 16'h0006);
      waitRdy(11'h0C6);
      chk(q, 16'h3008);
      chk(16'(perTxValid), 16'h0000);
   endtask
   task automatic tDma();
      io(11'h0C9, 16'h0100, 1'b1);
      io(11'h0CB, 16'h0003, 1'b1);
      chk(16'(dmaReq), 16'h0000);
      io(11'h0CD, 16'h0042, 1'b1);
      io(11'h0CE, 16'h0000, 1'b1);
      chk(q, 16'h0042);
      chk(dmaDevAddr, 16'h0042);
      io(11'h0CF, 16'h0865, 1'b1);
      chk(16'(dmaReq), 16'h0001);
      chk(16'(dmaAddr[17:16]), 16'h0003);
      chk(16'(dmaWrite), 16'h0001);
      waitRdy(11'h0CA);
      chk(q, 16'h0809);
      io(11'h0C8, 16'h0000, 1'b1);
      chk(q, 16'h0103);
      ident(9'h003);
      ident(9'h000);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      tStatus();
      tInput();
      tOutput();
      tDma();
      finalReport();
   end
endmodule
